// *** design/gpio_i2c_cfg.svh ***
`ifndef GPIO_I2C_CFG_SVH
`define GPIO_I2C_CFG_SVH

// target addresses, 7 bit
`define ADDR_BASE          7'h20
`define ADDR_ALT           7'h21
`define GENERAL_CALL       7'h00
// ten-bit addressing prefix, upper five bits 11110
`define TEN_BIT_PREFIX     5'h1e
// channel counts of the variants
`define CH_SMALL           4
`define CH_MID             8
`define CH_LARGE           16
// register counts per variant
`define NREG_SMALL         12
`define NREG_MID           16
`define NREG_LARGE         31
// bus bit-rate limits, kbit/s
`define RATE_STD_KBPS      100
`define RATE_FAST_KBPS     400
`define BITS_PER_BYTE      4'h8

`endif

// *** design/gpio_i2c_pkg.sv ***
package gpio_i2c_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK  = 3'b010,
        ST_PTR  = 3'b011,
        ST_WDAT = 3'b100,
        ST_RDAT = 3'b101,
        ST_RACK = 3'b110,
        ST_SKIP = 3'b111
    } state_t;
endpackage

// *** design/gpio_expander_i2c_slave_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gpio_i2c_cfg.svh"

// How it works
// - target only; never drives the clock line, only answers on data line.
// - small and mid variants answer 0x20 or 0x21 chosen by address pin.
// - large variant answers only 0x20, pin ignored.
// - pointer reaches 12, 16 or 31 registers; each reachable alone.
// - only 7-bit addresses; ten-bit prefix never matches.
// - general call address is never acknowledged.
// - sampling at 100 MHz keeps up with standard and fast rates.
// - direction bit 0 means write, 1 means read.
// - write: address, ack, pointer, ack, data, ack; data stored at pointer.
// - large variant increments pointer after each acknowledged data byte.
// - small and mid variants never step the pointer.
// - combined read returns the pointed byte after repeated start.
// - repeated start restarts address recognition without stop.
// - large variant reads next register while master acknowledges.
// - pointer kept across stop and foreign traffic.
module gpio_expander_i2c_slave_port #(
    parameter int CHANNELS = `CH_MID
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       addr_sel_pin,
    input  wire logic       reset_in_out_pin_b,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_we,
    output logic            reg_re,
    input  wire logic [7:0] reg_rdata
);
    localparam int  NREG     = (CHANNELS == `CH_LARGE) ? `NREG_LARGE :
                               (CHANNELS == `CH_MID) ? `NREG_MID : `NREG_SMALL;
    localparam bit  AUTO_INC = (CHANNELS == `CH_LARGE);
    localparam logic [7:0] LAST_REG = 8'(NREG - 1);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] scl_s_q, sda_s_q, rst_s_q, sel_s_q;
    logic       scl_q, sda_q;
    // two stages before any logic looks at the pins
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            rst_s_q <= 2'h0;
            sel_s_q <= 2'h0;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_in};
            sda_s_q <= {sda_s_q[0], sda_in};
            rst_s_q <= {rst_s_q[0], reset_in_out_pin_b};
            sel_s_q <= {sel_s_q[0], addr_sel_pin};   // strap pin may move at any time
            scl_q   <= scl_s_q[1];
            sda_q   <= sda_s_q[1];
        end
    end

    wire scl = scl_s_q[1];
    wire sda = sda_s_q[1];
    wire pin_rst = !rst_s_q[1];
    // edges and bus conditions; start covers repeated start too
    wire scl_rise = scl && !scl_q;
    wire scl_fall = !scl && scl_q;
    wire start_c  = scl && scl_q && sda_q && !sda;
    wire stop_c   = scl && scl_q && !sda_q && sda;

    // own address: pin only on small and mid variants
    wire [6:0] my_addr = (AUTO_INC || !sel_s_q[1]) ? `ADDR_BASE : `ADDR_ALT;

    // ----------------------------------------------------------------
    // protocol engine
    // ----------------------------------------------------------------
    gpio_i2c_pkg::state_t st_q, st_d;
    logic [7:0] sh_q, sh_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] ptr_q, ptr_d;
    logic       rd_q, rd_d;          // current phase is a read
    logic       adr_ph_q, adr_ph_d;  // ack follows address byte
    logic       ptr_ph_q, ptr_ph_d;  // next written byte is the pointer
    logic       sdo_q, sdo_d;
    logic       oe_q, oe_d;
    logic [7:0] wd_q, wd_d;
    logic       we_q, we_d, re_q, re_d;

    // pointer wraps inside the implemented register count
    function automatic logic [7:0] next_ptr(input logic [7:0] p);
        next_ptr = (p >= LAST_REG) ? 8'h00 : p + 8'h01;
    endfunction

    // next-state logic; sda only changes while scl is low to avoid fake start/stop
    always_comb begin
        st_d = st_q; sh_d = sh_q; cnt_d = cnt_q; ptr_d = ptr_q;
        rd_d = rd_q; adr_ph_d = adr_ph_q; ptr_ph_d = ptr_ph_q;
        sdo_d = sdo_q; oe_d = oe_q; wd_d = wd_q; we_d = 1'b0; re_d = 1'b0;
        if (pin_rst) begin
            st_d = gpio_i2c_pkg::ST_IDLE; oe_d = 1'b0; sdo_d = 1'b1;
            ptr_d = 8'h00;
        end else if (start_c) begin
            st_d = gpio_i2c_pkg::ST_ADDR; cnt_d = 4'h0; oe_d = 1'b0;
        end else if (stop_c) begin
            st_d = gpio_i2c_pkg::ST_IDLE; oe_d = 1'b0;   // pointer kept
        end else begin
            unique case (st_q)
                gpio_i2c_pkg::ST_IDLE, gpio_i2c_pkg::ST_SKIP: begin
                    oe_d = 1'b0;
                end
                gpio_i2c_pkg::ST_ADDR, gpio_i2c_pkg::ST_PTR, gpio_i2c_pkg::ST_WDAT: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == `BITS_PER_BYTE) begin
                        cnt_d = 4'h0;
                        if (st_q == gpio_i2c_pkg::ST_ADDR) begin
                            // general call, ten-bit prefix and foreign address never match
                            if (sh_q[7:1] == my_addr && sh_q[7:1] != `GENERAL_CALL
                                && sh_q[7:3] != `TEN_BIT_PREFIX) begin
                                rd_d = sh_q[0];
                                adr_ph_d = 1'b1;
                                st_d = gpio_i2c_pkg::ST_ACK; oe_d = 1'b1; sdo_d = 1'b0;
                            end else begin
                                st_d = gpio_i2c_pkg::ST_SKIP;
                            end
                        end else begin
                            adr_ph_d = 1'b0;
                            if (st_q == gpio_i2c_pkg::ST_PTR) begin
                                ptr_d = sh_q;
                            end else begin
                                wd_d = sh_q;
                                we_d = 1'b1;
                            end
                            st_d = gpio_i2c_pkg::ST_ACK; oe_d = 1'b1; sdo_d = 1'b0;
                        end
                    end
                end
                gpio_i2c_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (rd_q && adr_ph_q) begin
                            st_d = gpio_i2c_pkg::ST_RDAT;
                            sh_d = reg_rdata; re_d = 1'b1;
                            sdo_d = reg_rdata[7]; oe_d = !reg_rdata[7];
                            cnt_d = 4'h1;
                        end else begin
                            oe_d = 1'b0; sdo_d = 1'b1;
                            st_d = adr_ph_q ? gpio_i2c_pkg::ST_PTR : gpio_i2c_pkg::ST_WDAT;
                            if (!adr_ph_q && !ptr_ph_q && AUTO_INC)
                                ptr_d = next_ptr(ptr_q);
                            ptr_ph_d = 1'b0;
                        end
                    end
                end
                gpio_i2c_pkg::ST_RDAT: begin
                    if (scl_fall) begin
                        if (cnt_q == `BITS_PER_BYTE) begin
                            oe_d = 1'b0; sdo_d = 1'b1;
                            st_d = gpio_i2c_pkg::ST_RACK;
                        end else begin
                            sdo_d = sh_q[3'(7 - cnt_q)];
                            oe_d  = !sh_q[3'(7 - cnt_q)];          // open drain, drive low only
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                gpio_i2c_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        if (sda) begin
                            st_d = gpio_i2c_pkg::ST_SKIP;          // nack ends the read
                        end else if (AUTO_INC) begin
                            ptr_d = next_ptr(ptr_q);
                            adr_ph_d = 1'b1;
                            st_d = gpio_i2c_pkg::ST_ACK;           // reload on next fall
                        end else begin
                            adr_ph_d = 1'b1;
                            st_d = gpio_i2c_pkg::ST_ACK;
                        end
                    end
                end
            endcase
        end
        // pointer byte is expected first after an address ack in write direction
        if (st_d == gpio_i2c_pkg::ST_PTR) ptr_ph_d = 1'b1;
        if (st_q == gpio_i2c_pkg::ST_RACK && st_d == gpio_i2c_pkg::ST_ACK) oe_d = 1'b0;
    end

    // ack stall after master ack: ACK state with oe low just waits for the fall
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= gpio_i2c_pkg::ST_IDLE; sh_q <= 8'h00; cnt_q <= 4'h0;
            ptr_q <= 8'h00; rd_q <= 1'b0; adr_ph_q <= 1'b0; ptr_ph_q <= 1'b0;
            sdo_q <= 1'b1; oe_q <= 1'b0; wd_q <= 8'h00; we_q <= 1'b0; re_q <= 1'b0;
        end else begin
            st_q <= st_d; sh_q <= sh_d; cnt_q <= cnt_d;
            ptr_q <= ptr_d; rd_q <= rd_d; adr_ph_q <= adr_ph_d; ptr_ph_q <= ptr_ph_d;
            sdo_q <= sdo_d; oe_q <= oe_d; wd_q <= wd_d; we_q <= we_d; re_q <= re_d;
        end
    end

    // the clock line is never driven: pure target
    assign sda_out   = sdo_q;
    assign sda_oe    = oe_q;
    assign reg_addr  = ptr_q;
    assign reg_wdata = wd_q;
    assign reg_we    = we_q;
    assign reg_re    = re_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_no_gc_ack;
        @(posedge clock) disable iff (!rst_b)
        (st_q == gpio_i2c_pkg::ST_ADDR && scl_fall && cnt_q == 4'h8 && sh_q[7:1] == 7'h00)
        |=> !oe_q;
    endproperty
    a_no_gc_ack: assert property (p_no_gc_ack) else $error("general call acked");

    property p_fixed_ptr;
        @(posedge clock) disable iff (!rst_b)
        (!AUTO_INC && st_q != gpio_i2c_pkg::ST_PTR) |=> $stable(ptr_q) || pin_rst;
    endproperty
    a_fixed_ptr: assert property (p_fixed_ptr) else $error("pointer moved");

    property p_skip_quiet;
        @(posedge clock) disable iff (!rst_b)
        (st_q == gpio_i2c_pkg::ST_SKIP) |-> !oe_q;
    endproperty
    a_skip_quiet: assert property (p_skip_quiet) else $error("drive in skip");

    property p_start_restart;
        @(posedge clock) disable iff (!rst_b)
        (start_c && !pin_rst) |=> st_q == gpio_i2c_pkg::ST_ADDR && cnt_q == 4'h0;
    endproperty
    a_start_restart: assert property (p_start_restart) else $error("start missed");

    // a store pulse only closes a data byte, and the ack is on the line with it
    property p_we_data;
        @(posedge clock) disable iff (!rst_b)
        we_q |-> $past(st_q) == gpio_i2c_pkg::ST_WDAT && st_q == gpio_i2c_pkg::ST_ACK && oe_q;
    endproperty
    a_we_data: assert property (p_we_data) else $error("store outside data byte");

    // an address that is not ours drops the port into the quiet skip state
    property p_foreign_skip;
        @(posedge clock) disable iff (!rst_b)
        (st_q == gpio_i2c_pkg::ST_ADDR && scl_fall && cnt_q == 4'h8 && sh_q[7:1] != my_addr
         && !start_c && !stop_c && !pin_rst) |=> st_q == gpio_i2c_pkg::ST_SKIP && !oe_q;
    endproperty
    a_foreign_skip: assert property (p_foreign_skip) else $error("foreign address taken");
endmodule
`default_nettype wire

// *** bench/i2c_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// bus master model: 80 ns bus clock, open-drain data where a 1 releases the line
module i2c_master_model (
    input  wire logic clock,
    input  wire logic sda_line,
    output var logic  scl,
    output var logic  sda_m
);
    // both lines idle high; the bus clock stands still between frames
    initial {scl, sda_m} = 2'b11;
    // a quarter of the 80 ns bus-clock period; compressed rate, still long against the port's sync lag
    task automatic step(input logic c, input logic d);
        {scl, sda_m} <= {c, d};
        repeat (2) @(posedge clock);
    endtask
    // start when open is set, stop otherwise; data rises first so restarts work too
    task automatic cond(input logic open);
        step(scl, open);
        step(1'b1, open);
        step(1'b1, ~open);
        if (open) step(1'b0, 1'b0);
    endtask
    // eight bits msb first, then the ninth; line sampled late in the high phase
    task automatic xfer(input logic [7:0] tx, input logic ninth, output logic [7:0] rx, output logic low9);
        logic [8:0] f;
        f = {tx, ninth};
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, f[i]);
            step(1'b1, f[i]);
            step(1'b1, f[i]);
            f[i] = sda_line;
            step(1'b0, sda_m);
        end
        rx = f[8:1];
        low9 = ~f[0];
    endtask
endmodule
`default_nettype wire

// *** bench/gpio_expander_i2c_slave_port_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpio_expander_i2c_slave_port_bench;
    logic       clock, rst_b, addr_sel_pin, reset_in_out_pin_b;
    logic       scl, sda_m, sda_out, sda_oe, reg_we, reg_re, ack;
    logic [7:0] reg_addr, reg_wdata, rd;
    logic [7:0] mem [0:255] = '{default: 8'h00};
    int         n_fail = 0, checked = 0, n_we = 0, n_re = 0;
    // pull-up on the data line; the port can only pull it low
    wire        sda_line = sda_m & (sda_oe ? sda_out : 1'b1);
    wire  [7:0] reg_rdata = mem[reg_addr];
    // 100 MHz clock, master model and the 8-channel port
    always #5 clock = ~clock;
    i2c_master_model mst (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
    gpio_expander_i2c_slave_port #(.CHANNELS(8)) dut_u (
        .clock(clock), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_sel_pin(addr_sel_pin), .reset_in_out_pin_b(reset_in_out_pin_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
    // register bank behind the port, counting stores
    always @(posedge clock) begin
        if (reg_we === 1'b1) begin
            mem[reg_addr] <= reg_wdata;
            n_we <= n_we + 1;
        end
        if (reg_re === 1'b1) n_re <= n_re + 1;
    end
    task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic summarize;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one byte, after a start if rs; checks the eight line bits and the ninth as low
    task automatic io(input logic rs, input logic [7:0] tx, input logic ninth, input logic [8:0] exp);
        if (rs) mst.cond(1'b1);
        mst.xfer(tx, ninth, rd, ack);
        cmp("byte", exp, {rd, ack});
    endtask
    // two bytes to the top register, then a combined read with a reread
    task automatic t_write_read;
        io(1'b1, 8'h40, 1'b1, 9'h081);
        io(1'b0, 8'h0f, 1'b1, 9'h01f);
        io(1'b0, 8'h11, 1'b1, 9'h023);
        io(1'b0, 8'h22, 1'b1, 9'h045);
        mst.cond(1'b0);
        cmp("pointer", 9'h00f, {1'b0, reg_addr});
        io(1'b1, 8'h40, 1'b1, 9'h081);
        io(1'b0, 8'h0f, 1'b1, 9'h01f);
        io(1'b1, 8'h41, 1'b1, 9'h083);
        io(1'b0, 8'hff, 1'b0, 9'h045);
        io(1'b0, 8'hff, 1'b1, 9'h044);
        mst.cond(1'b0);
    endtask
    // refused addresses and foreign traffic, then a later read of the kept pointer
    task automatic t_stop_sep;
        logic [7:0] bad [3] = '{8'h00, 8'hf0, 8'h66};
        foreach (bad[i]) begin
            io(1'b1, bad[i], 1'b1, {bad[i], 1'b0});
            io(1'b0, 8'h55, 1'b1, 9'h0aa);
            mst.cond(1'b0);
        end
        cmp("stores", 9'h002, 9'(n_we));
        io(1'b1, 8'h41, 1'b1, 9'h083);
        io(1'b0, 8'hff, 1'b1, 9'h044);
        mst.cond(1'b0);
        cmp("reads", 9'h003, 9'(n_re));
    endtask
    // device reset pin clears the pointer; the address pin moves the port to 0x21
    task automatic t_pins;
        addr_sel_pin <= 1'b1;
        reset_in_out_pin_b <= 1'b0;
        repeat (8) @(posedge clock);
        cmp("pointer", 9'h000, {1'b0, reg_addr});
        reset_in_out_pin_b <= 1'b1;
        repeat (8) @(posedge clock);
        io(1'b1, 8'h40, 1'b1, 9'h080);
        mst.cond(1'b0);
        io(1'b1, 8'h42, 1'b1, 9'h085);
        mst.cond(1'b0);
    endtask
    // reset, then the scenarios in turn
    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        addr_sel_pin = 1'b0;
        reset_in_out_pin_b = 1'b1;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        repeat (8) @(posedge clock);
        t_write_read();
        t_stop_sep();
        t_pins();
        summarize();
    end
    // watchdog: the run needs some 1500 cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        summarize();
    end
endmodule
`default_nettype wire
